// file: logic/sfr_device.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_device
  import sfr_pkg::*;
(
  input wire logic rst_n,
  input wire logic [7:0] mem_rdata,
  input wire logic busy_in,
  input wire logic extended_addr_bit,
  input wire logic dummy_cycle_sel_lo,
  input wire logic dummy_cycle_sel_hi,
  output logic [31:0] mem_addr,
  output logic wide_addr_flag,
  sfr_link_if.device link
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sfr_dev_state_t state_reg, state_next;
  logic [5:0] cnt_reg;
  logic [7:0] op_reg;
  logic [31:0] addr_reg;
  logic wide_reg;
  logic [1:0] io_o_reg;
  logic [1:0] io_oe_reg;
  logic busy_s, ext_s, sel_hi_s, sel_lo_s;

  // the link clock only runs inside frames, so these settle
  // two edges into the next command
  sfr_sync #(.W(4)) u_sync (
    .clk(link.sclk),
    .rst_n(rst_n),
    .d({busy_in, extended_addr_bit, dummy_cycle_sel_hi, dummy_cycle_sel_lo}),
    .q({busy_s, ext_s, sel_hi_s, sel_lo_s})
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [7:0] op_in = {op_reg[6:0], link.io[0]};
  wire dual_io = sfr_is_dual_io(op_reg);
  wire dual_data = sfr_is_dual_data(op_reg);
  wire [5:0] addr_clks = sfr_addr_clks(op_reg, wide_reg);
  wire [5:0] dummy_clks = sfr_dummy_clks(op_reg, {sel_hi_s, sel_lo_s});
  wire [5:0] byte_clks = dual_data ? DUAL_BYTE_CLKS : SINGLE_BYTE_CLKS;
  wire cmd_last = state_reg == D_CMD && cnt_reg == OPCODE_LAST;
  wire reject = busy_s && op_in != READ_CMD;
  wire byte_end = state_reg == D_DATA && cnt_reg == byte_clks - 6'd1;
  wire [31:0] addr_in = dual_io ? {addr_reg[29:0], link.io[1], link.io[0]}
                                : {addr_reg[30:0], link.io[0]};
  // narrow mode takes the upper bit from the extended address bit
  wire [31:0] addr_full = wide_reg ? addr_in : {7'h00, ext_s, addr_in[23:0]};
  wire [31:0] addr_wrap = (addr_reg + 32'h1) & ARRAY_ADDR_MASK;
  wire [7:0] out_sel = mem_rdata << (dual_data ? {cnt_reg[1:0], 1'b0} : cnt_reg[2:0]);
  wire [1:0] out_bits = dual_data ? out_sel[7:6] : {out_sel[7], 1'b0};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      D_CMD: begin
        if (cmd_last) begin
          state_next = (sfr_is_read(op_in) && !reject) ? D_ADDR : D_IGNORE;
        end
      end
      D_ADDR: begin
        if (cnt_reg == addr_clks - 6'd1) begin
          state_next = (dummy_clks != 6'd0) ? D_DUMMY : D_DATA;
        end
      end
      D_DUMMY: begin
        if (cnt_reg == dummy_clks - 6'd1) begin
          state_next = D_DATA;
        end
      end
      D_DATA: state_next = D_DATA;
      D_IGNORE: state_next = D_IGNORE;
    endcase
  end

  // ---------------------------------------------------------------
  // rising-edge side: command, address, dummy and byte counting
  // ---------------------------------------------------------------
  // chip select high clears the frame whatever phase it reached
  always_ff @(posedge link.sclk or negedge rst_n or posedge link.cs_n) begin
    if (!rst_n || link.cs_n) begin
      state_reg <= D_CMD;
      cnt_reg <= 6'h00;
      op_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg || byte_end) ? 6'h00 : cnt_reg + 6'h01;
      if (state_reg == D_CMD) begin
        op_reg <= op_in;
      end
    end
  end

  // address counter outlives chip select so the last position stays visible;
  // every address phase overwrites all the bits it uses
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 32'h0;
    end else if (!link.cs_n && state_reg == D_ADDR) begin
      addr_reg <= (state_next != state_reg) ? (addr_full & ARRAY_ADDR_MASK) : addr_in;
    end else if (!link.cs_n && byte_end) begin
      addr_reg <= addr_wrap;
    end
  end

  // mode flag survives chip select; only its own commands or reset move it
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      wide_reg <= 1'b0;
    end else if (cmd_last && op_in == ENTER_WIDE_ADDR_CMD) begin
      wide_reg <= 1'b1;
    end else if (cmd_last && op_in == EXIT_WIDE_ADDR_CMD) begin
      wide_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // falling-edge side: data out
  // ---------------------------------------------------------------
  always_ff @(negedge link.sclk or negedge rst_n or posedge link.cs_n) begin
    if (!rst_n || link.cs_n) begin
      io_o_reg <= 2'h0;
      io_oe_reg <= 2'h0;
    end else if (state_reg == D_DATA) begin
      io_o_reg <= out_bits;
      io_oe_reg <= dual_data ? 2'h3 : 2'h2;
    end else begin
      io_o_reg <= 2'h0;
      io_oe_reg <= 2'h0;
    end
  end

  assign link.dev_io_o = io_o_reg;
  assign link.dev_io_oe = io_oe_reg;
  assign mem_addr = addr_reg;
  assign wide_addr_flag = wide_reg;
endmodule : sfr_device
`default_nettype wire

// file: logic/sfr_host.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module sfr_host
  import sfr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  sfr_link_if.host link
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sfr_host_state_t state_reg, state_next;
  logic cs_n_reg, sclk_reg;
  logic [1:0] io_o_reg, io_oe_reg, io_s;
  logic [3:0] ph_reg;
  logic [5:0] cnt_reg;
  logic [7:0] op_reg, len_reg, left_reg, rx_reg, data_reg;
  logic [39:0] sh_reg;
  logic [31:0] addr_reg, rdata_reg;
  logic [1:0] dsel_reg;
  logic wide_reg, valid_reg;

  sfr_sync #(.W(2)) u_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(link.io),
    .q(io_s)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire busy = state_reg != H_IDLE;
  wire step = busy && ph_reg == SCLK_PERIOD - 4'd1;
  wire dual_io = sfr_is_dual_io(op_reg);
  wire dual_data = sfr_is_dual_data(op_reg);
  wire [5:0] addr_clks = sfr_addr_clks(op_reg, wide_reg);
  wire [5:0] dummy_clks = sfr_dummy_clks(op_reg, dsel_reg);
  wire [5:0] byte_clks = dual_data ? DUAL_BYTE_CLKS : SINGLE_BYTE_CLKS;
  wire cmd_last = state_reg == H_CMD && cnt_reg == OPCODE_LAST;
  wire byte_done = step && state_reg == H_DATA && cnt_reg == byte_clks - 6'd1;
  wire [39:0] sh_next = (state_reg == H_ADDR && dual_io) ? {sh_reg[37:0], 2'b00}
                                                         : {sh_reg[38:0], 1'b0};
  wire [7:0] rx_next = dual_data ? {rx_reg[5:0], io_s} : {rx_reg[6:0], io_s[1]};
  wire start = reg_wr && reg_addr == REG_CMD && !busy;
  wire [7:0] start_op = reg_wdata[7:0];
  wire [39:0] start_sh = wide_reg ? {start_op, addr_reg} : {start_op, addr_reg[23:0], 8'h00};
  wire [7:0] cfg_val = {dsel_reg, wide_reg, 5'h00};
  wire [31:0] rd_mux = (reg_addr == REG_CMD) ? {24'h0, op_reg} :
                       (reg_addr == REG_ADDR) ? addr_reg :
                       (reg_addr == REG_LEN) ? {24'h0, len_reg} :
                       (reg_addr == REG_CFG) ? {24'h0, cfg_val} :
                       (reg_addr == REG_STAT) ? {30'h0, valid_reg, busy} :
                       (reg_addr == REG_DATA) ? {24'h0, data_reg} : 32'h0;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      H_IDLE: begin
        if (start) begin
          state_next = H_CMD;
        end
      end
      H_CMD: begin
        if (step && cmd_last) begin
          state_next = sfr_is_read(op_reg) ? H_ADDR : H_IDLE;
        end
      end
      H_ADDR: begin
        if (step && cnt_reg == addr_clks - 6'd1) begin
          state_next = (dummy_clks != 6'd0) ? H_DUMMY : H_DATA;
        end
      end
      H_DUMMY: begin
        if (step && cnt_reg == dummy_clks - 6'd1) begin
          state_next = H_DATA;
        end
      end
      H_DATA: begin
        if (byte_done && left_reg == 8'h01) begin
          state_next = H_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // link sequencer; outputs other than sclk change only at frame start or as the serial clock falls
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= H_IDLE;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      io_o_reg <= 2'h0;
      io_oe_reg <= 2'h0;
      ph_reg <= 4'h0;
      cnt_reg <= 6'h00;
      op_reg <= 8'h00;
      sh_reg <= 40'h0;
      left_reg <= 8'h00;
      rx_reg <= 8'h00;
      wide_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        op_reg <= start_op;
        sh_reg <= start_sh;
        cs_n_reg <= 1'b0;
        ph_reg <= 4'h0;
        cnt_reg <= 6'h00;
        io_o_reg <= {1'b0, start_op[7]};
        io_oe_reg <= 2'h1;
        left_reg <= (len_reg == 8'h00) ? 8'h01 : len_reg;
      end else if (busy) begin
        ph_reg <= step ? 4'h0 : ph_reg + 4'h1;
        if (ph_reg == SCLK_HALF - 4'd1) begin
          sclk_reg <= 1'b1;
        end
        if (step) begin
          sclk_reg <= 1'b0;
          sh_reg <= sh_next;
          cnt_reg <= (state_next != state_reg || byte_done) ? 6'h00 : cnt_reg + 6'h01;
          io_o_reg <= {sh_next[39], (state_next == H_ADDR && dual_io) ? sh_next[38]
                                                                      : sh_next[39]};
          io_oe_reg <= (state_next == H_CMD) ? 2'h1 :
                       (state_next == H_ADDR) ? (dual_io ? 2'h3 : 2'h1) : 2'h0;
          if (state_reg == H_DATA) begin
            rx_reg <= rx_next;
          end
          if (byte_done) begin
            left_reg <= left_reg - 8'h01;
          end
          if (state_next == H_IDLE) begin
            cs_n_reg <= 1'b1;
          end
          if (cmd_last && op_reg == ENTER_WIDE_ADDR_CMD) begin
            wide_reg <= 1'b1;
          end else if (cmd_last && op_reg == EXIT_WIDE_ADDR_CMD) begin
            wide_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 32'h0;
      len_reg <= 8'h01;
      dsel_reg <= 2'h0;
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h0;
      // settings hold still while a frame is running
      if (reg_wr && !busy && reg_addr == REG_ADDR) begin
        addr_reg <= reg_wdata;
      end
      if (reg_wr && !busy && reg_addr == REG_LEN) begin
        len_reg <= reg_wdata[7:0];
      end
      if (reg_wr && !busy && reg_addr == REG_CFG) begin
        dsel_reg <= {reg_wdata[CFG_DUMMY_HI_POS], reg_wdata[CFG_DUMMY_LO_POS]};
      end
      if (byte_done) begin
        data_reg <= rx_next;
      end
      // a byte landing with the read still counts
      valid_reg <= byte_done | (valid_reg & !(reg_rd && reg_addr == REG_DATA));
    end
  end

  assign reg_rdata = rdata_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.host_io_o = io_o_reg;
  assign link.host_io_oe = io_oe_reg;
endmodule : sfr_host
`default_nettype wire

// file: logic/sfr_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfr_link_if;
  logic cs_n;
  logic sclk;
  logic [1:0] host_io_o;
  logic [1:0] host_io_oe;
  logic [1:0] dev_io_o;
  logic [1:0] dev_io_oe;
  logic [1:0] io;

  // undriven lines read low; a real board would hold them with pulls
  assign io[0] = host_io_oe[0] ? host_io_o[0] : (dev_io_oe[0] & dev_io_o[0]);
  assign io[1] = host_io_oe[1] ? host_io_o[1] : (dev_io_oe[1] & dev_io_o[1]);

  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
  modport device (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface : sfr_link_if
`default_nettype wire

// file: logic/sfr_pkg.sv
`default_nettype none
package sfr_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0b;
  localparam logic [7:0] DUAL_OUTPUT_READ_CMD = 8'h3b;
  localparam logic [7:0] DUAL_IO_READ_CMD = 8'hbb;
  localparam logic [7:0] ENTER_WIDE_ADDR_CMD = 8'hb7;
  localparam logic [7:0] EXIT_WIDE_ADDR_CMD = 8'he9;
  localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5a;
  localparam logic [7:0] SIGNATURE_READ_CMD = 8'hab;
  localparam logic [7:0] MAKER_DEVICE_ID_READ_CMD = 8'h90;

  // ---------------------------------------------------------------
  // address and dummy phase lengths
  // ---------------------------------------------------------------
  localparam logic [5:0] NARROW_ADDR_BITS = 6'd24;
  localparam logic [5:0] WIDE_ADDR_BITS = 6'd32;
  localparam logic [5:0] OPCODE_LAST = 6'd7;
  // array size is a plain default; wraps after the highest location
  localparam logic [31:0] ARRAY_ADDR_MASK = 32'h01ff_ffff;
  localparam logic [5:0] FAST_DUMMY_CLKS = 6'd8;
  localparam logic [5:0] DUAL_OUT_DUMMY_CLKS = 6'd8;
  localparam logic [5:0] DUAL_IO_DUMMY_CLKS = 6'd4;
  localparam logic [5:0] DUMMY_SEL1_CLKS = 6'd6;
  localparam logic [5:0] DUMMY_SEL2_CLKS = 6'd10;
  localparam logic [5:0] DUMMY_SEL3_CLKS = 6'd12;
  localparam logic [5:0] SINGLE_BYTE_CLKS = 6'd8;
  localparam logic [5:0] DUAL_BYTE_CLKS = 6'd4;

  // ---------------------------------------------------------------
  // host timing and register map
  // ---------------------------------------------------------------
  localparam logic [3:0] SCLK_HALF = 4'd4;
  localparam logic [3:0] SCLK_PERIOD = 4'd8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam int CFG_WIDE_POS = 5;
  localparam int CFG_DUMMY_LO_POS = 6;
  localparam int CFG_DUMMY_HI_POS = 7;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_VALID_POS = 1;

  typedef enum logic [2:0] {D_CMD, D_ADDR, D_DUMMY, D_DATA, D_IGNORE} sfr_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_ADDR, H_DUMMY, H_DATA} sfr_host_state_t;

  // ---------------------------------------------------------------
  // shared decoding
  // ---------------------------------------------------------------
  function automatic logic sfr_is_read(input logic [7:0] op);
    return op == READ_CMD || op == FAST_READ_CMD || op == DUAL_OUTPUT_READ_CMD ||
           op == DUAL_IO_READ_CMD;
  endfunction : sfr_is_read

  function automatic logic sfr_is_dual_io(input logic [7:0] op);
    return op == DUAL_IO_READ_CMD;
  endfunction : sfr_is_dual_io

  function automatic logic sfr_is_dual_data(input logic [7:0] op);
    return op == DUAL_IO_READ_CMD || op == DUAL_OUTPUT_READ_CMD;
  endfunction : sfr_is_dual_data

  // clocks in the address phase
  function automatic logic [5:0] sfr_addr_clks(input logic [7:0] op, input logic wide);
    logic [5:0] bits;
    bits = wide ? WIDE_ADDR_BITS : NARROW_ADDR_BITS;
    if (op == PARAM_TABLE_READ_CMD || op == SIGNATURE_READ_CMD ||
        op == MAKER_DEVICE_ID_READ_CMD) begin
      bits = NARROW_ADDR_BITS;
    end
    return sfr_is_dual_io(op) ? {1'b0, bits[5:1]} : bits;
  endfunction : sfr_addr_clks

  // dummy clocks; the select field only retunes the dual reads
  function automatic logic [5:0] sfr_dummy_clks(input logic [7:0] op, input logic [1:0] sel);
    logic [5:0] tbl;
    tbl = (sel == 2'h1) ? DUMMY_SEL1_CLKS : (sel == 2'h2) ? DUMMY_SEL2_CLKS : DUMMY_SEL3_CLKS;
    if (op == FAST_READ_CMD) begin
      return FAST_DUMMY_CLKS;
    end else if (op == DUAL_OUTPUT_READ_CMD) begin
      return (sel == 2'h0) ? DUAL_OUT_DUMMY_CLKS : tbl;
    end else if (op == DUAL_IO_READ_CMD) begin
      return (sel == 2'h0) ? DUAL_IO_DUMMY_CLKS : tbl;
    end
    return 6'd0;
  endfunction : sfr_dummy_clks
endpackage : sfr_pkg
`default_nettype wire

// file: logic/sfr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sfr_sync
`default_nettype wire

// file: verification/serial_flash_read_addr_mode_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_read_addr_mode_tb_top;
  import sfr_pkg::*;
  localparam logic [7:0] RD_OPS [4] = '{READ_CMD, FAST_READ_CMD, DUAL_OUTPUT_READ_CMD,
                                        DUAL_IO_READ_CMD};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic busy_in = 1'b0;
  logic ext_bit = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [31:0] mem_addr;
  logic wide_addr_flag;
  logic [31:0] rd_val;
  int fails = 0;
  int tests_run = 0;

  sfr_link_if link ();
  always #25 sys_clk = ~sys_clk;

  // array contents: a function of the address, so wraps are visible
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ {a[24], a[15:9]};
  endfunction : pat

  sfr_host i_sfr_host (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link.host));
  sfr_device i_sfr_device (.rst_n(rst_n), .mem_rdata(pat(mem_addr)), .busy_in(busy_in),
    .extended_addr_bit(ext_bit), .dummy_cycle_sel_lo(sel[0]), .dummy_cycle_sel_hi(sel[1]),
    .mem_addr(mem_addr), .wide_addr_flag(wide_addr_flag), .link(link.device));
  sfr_link_props i_sfr_link_props (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe),
    .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe), .io(link.io),
    .wide_addr_flag(wide_addr_flag));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // one frame, then the last byte lands in rd_val
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] len);
    int n;
    wr(REG_CFG, {24'h0, sel, 6'h0});
    wr(REG_ADDR, a);
    wr(REG_LEN, {24'h0, len});
    wr(REG_CMD, {24'h0, op});
    n = 0;
    rd(REG_STAT);
    while (rd_val[STAT_BUSY_POS] !== 1'b0 && n < 400) begin
      rd(REG_STAT);
      n++;
    end
    if (n >= 400) fails++;
    rd(REG_DATA);
  endtask : frame

  task automatic rdchk(input logic [7:0] op, input logic [31:0] a, input logic [31:0] dev_a);
    frame(op, a, 8'h01);
    check(rd_val, {24'h0, pat(dev_a)});
    check(mem_addr, dev_a + 32'h1);
  endtask : rdchk

  // synced device pins need a frame of sclk before they count
  task automatic settle;
    frame(EXIT_WIDE_ADDR_CMD, 32'h0, 8'h01);
  endtask : settle

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check({31'h0, wide_addr_flag}, 32'h0);
    rd(REG_CFG);
    check(rd_val & 32'h20, 32'h0);
    rd(8'hfc);
    check(rd_val, 32'h0);
    rdchk(READ_CMD, 32'h7700_1234, 32'h0000_1234);
  endtask : t_reset

  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      rdchk(RD_OPS[i], 32'h3a5c + i, 32'h3a5c + i);
    end
  endtask : t_modes

  task automatic t_wide;
    frame(ENTER_WIDE_ADDR_CMD, 32'h0, 8'h01);
    check({31'h0, wide_addr_flag}, 32'h1);
    rd(REG_CFG);
    check(rd_val & 32'h20, 32'h20);
    frame(PARAM_TABLE_READ_CMD, 32'h0, 8'h01);
    check({31'h0, wide_addr_flag}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rdchk(RD_OPS[i], 32'h0123_4560 + i, 32'h0123_4560 + i);
    end
    frame(READ_CMD, 32'h01ff_ffff, 8'h02);
    check(rd_val, {24'h0, pat(32'h0)});
    check(mem_addr, 32'h1);
    frame(EXIT_WIDE_ADDR_CMD, 32'h0, 8'h01);
    check({31'h0, wide_addr_flag}, 32'h0);
    rd(REG_CFG);
    check(rd_val & 32'h20, 32'h0);
    rdchk(READ_CMD, 32'h0123_4567, 32'h0023_4567);
  endtask : t_wide

  task automatic t_ext;
    @(posedge sys_clk);
    ext_bit <= 1'b1;
    settle();
    rdchk(READ_CMD, 32'h0000_0010, 32'h0100_0010);
    @(posedge sys_clk);
    ext_bit <= 1'b0;
    settle();
  endtask : t_ext

  task automatic t_dummy;
    for (int s = 1; s < 4; s++) begin
      @(posedge sys_clk);
      sel <= s[1:0];
      settle();
      rdchk(DUAL_OUTPUT_READ_CMD, 32'h200 + s, 32'h200 + s);
      rdchk(DUAL_IO_READ_CMD, 32'h300 + s, 32'h300 + s);
    end
    @(posedge sys_clk);
    sel <= 2'h0;
    settle();
  endtask : t_dummy

  // rejected reads leave the lines undriven, so the host sees zeros
  task automatic t_busy;
    @(posedge sys_clk);
    busy_in <= 1'b1;
    settle();
    rdchk(READ_CMD, 32'h40, 32'h40);
    for (int i = 1; i < 4; i++) begin
      frame(RD_OPS[i], 32'h41, 8'h01);
      check(rd_val, 32'h0);
    end
    @(posedge sys_clk);
    busy_in <= 1'b0;
    settle();
  endtask : t_busy

  task automatic conclude;
    $display("checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_wide();
    t_ext();
    t_dummy();
    t_busy();
    conclude();
  end

  // about nine times the expected run length
  initial begin
    #(80000 * 50);
    fails++;
    conclude();
  end
endmodule : serial_flash_read_addr_mode_tb_top
`default_nettype wire

// file: verification/sfr_link_props.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_link_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [1:0] host_io_o,
  input wire logic [1:0] host_io_oe,
  input wire logic [1:0] dev_io_o,
  input wire logic [1:0] dev_io_oe,
  input wire logic [1:0] io,
  input wire logic wide_addr_flag
);
  // ---------------------------------------------------------------
  // rising sclk edges in the current frame
  // ---------------------------------------------------------------
  // 8 bits hold every frame length this bench makes
  logic sclk_d_reg;
  logic [7:0] rise_reg;
  logic [7:0] rise_next;
  wire logic rise_now;
  wire logic [7:0] rise_cnt;
  assign rise_now = sclk & ~sclk_d_reg;
  assign rise_cnt = rise_reg + {7'h00, rise_now};
  assign rise_next = cs_n ? 8'h00 : rise_cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
      rise_reg <= 8'h00;
    end else begin
      sclk_d_reg <= sclk;
      rise_reg <= rise_next;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_NO_CONTENTION: assert property (
    dev_io_oe != 2'b00 |-> host_io_oe == 2'b00 && io == dev_io_o)
    else $error("both ends drive the io lines");
  AST_RELEASE_IDLE: assert property (
    cs_n && $past(cs_n) |-> dev_io_oe == 2'b00)
    else $error("device drives while deselected");
  AST_DATA_ON_FALL: assert property (
    $changed(dev_io_o) |-> !sclk)
    else $error("device data changed while sclk high");
  AST_OE_ON_FALL: assert property (
    $changed(dev_io_oe) |-> !sclk)
    else $error("device enable changed while sclk high");
  AST_HOST_STABLE_RISE: assert property (
    $rose(sclk) |-> $stable(host_io_o) && $stable(host_io_oe))
    else $error("host io moved at the sampling edge");
  AST_SCLK_HIGH: assert property (
    $rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase not four cycles");
  AST_SCLK_LOW: assert property (
    $fell(sclk) |-> !sclk [*4])
    else $error("sclk low phase shorter than four cycles");
  AST_SCLK_IDLE: assert property (
    cs_n |-> !sclk)
    else $error("sclk active outside a frame");
  AST_DRIVE_AFTER_ADDR: assert property (
    dev_io_oe != 2'b00 |-> rise_cnt >= 8'd24)
    else $error("device drove before opcode and address");
  AST_FLAG_AT_OPCODE: assert property (
    $changed(wide_addr_flag) |-> !cs_n && rise_cnt == 8'd8)
    else $error("wide flag changed away from eighth opcode edge");
  AST_UPPER_ON_LINE1: assert property (
    dev_io_oe[0] |-> dev_io_oe[1])
    else $error("line 0 driven without line 1");

  cover property (wide_addr_flag && dev_io_oe == 2'b11);
endmodule : sfr_link_props
`default_nettype wire
